// file: fobc_top.sv
// finisher stacker: stapler shift, output bins, shutter, jam detection, power gating
`timescale 1ns/100ps
module fobc_top
	import fobc_pkg::*;
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// register bus
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic IRQ,
	// host commands
	input wire logic STAPLE_CMD,
	input wire logic [1:0] STAPLE_POS,
	input wire logic [1:0] PAPER_SIZE,
	input wire logic STAPLE_FIRE,
	input wire logic STACK_DONE,
	input wire logic STACK_BIN,
	input wire logic SHEET_START,
	// host reports
	output logic STAPLER_READY,
	output logic JAM_REPORT,
	output logic JAM_REPEAT,
	output logic DELIVERY_SUSPEND,
	// sensors and switches, index 0 upper bin, 1 lower bin
	input wire logic STAPLER_SHIFT_HOME_SENSOR,
	input wire logic STAPLER_INTERFERENCE_SENSOR,
	input wire logic [1:0] BIN_SURFACE_SENSOR,
	input wire logic [1:0] BIN_PAPER_SENSOR,
	input wire logic [1:0] AREA_SENSOR_FIRST,
	input wire logic [1:0] AREA_SENSOR_SECOND,
	input wire logic [1:0] AREA_SENSOR_THIRD,
	input wire logic UPPER_BIN_SAFETY_SWITCH,
	input wire logic SHUTTER_HOME_SENSOR,
	input wire logic PATH_ENTRY_SENSOR,
	input wire logic PATH_DELIVERY_SENSOR,
	input wire logic FRONT_COVER_SWITCH,
	input wire logic DOORS_CLOSED,
	// actuators
	output logic STAPLER_SHIFT_MOTOR_STEP,
	output logic STAPLER_SHIFT_MOTOR_DIR,
	output logic STAPLE_DRIVE_MOTOR,
	output logic [1:0] BIN_SHIFT_MOTOR_STEP,
	output logic [1:0] BIN_SHIFT_MOTOR_DIR,
	output logic STACK_EJECTION_MOTOR_STEP,
	output logic STACK_EJECTION_MOTOR_DIR,
	output logic SHUTTER_CLUTCH,
	output logic LOWER_ROLLER_CLUTCH,
	output logic MOTOR_POWER_EN,
	output logic UPPER_MOTOR_POWER_EN
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers
logic [17:0] raw;
logic [17:0] sync1_ff;
logic [17:0] sync2_ff;
assign raw = {DOORS_CLOSED, STAPLER_INTERFERENCE_SENSOR, FRONT_COVER_SWITCH, PATH_DELIVERY_SENSOR,
	PATH_ENTRY_SENSOR, SHUTTER_HOME_SENSOR, UPPER_BIN_SAFETY_SWITCH, AREA_SENSOR_THIRD,
	AREA_SENSOR_SECOND, AREA_SENSOR_FIRST, BIN_PAPER_SENSOR, BIN_SURFACE_SENSOR, STAPLER_SHIFT_HOME_SENSOR};
// two stages on every sensor and switch pin before any logic; host command pins are used unsynchronised
always_ff @(posedge MCLK) begin
	if (!RST_N) begin
		sync1_ff <= 18'h00000;
		sync2_ff <= 18'h00000;
	end else begin
		sync1_ff <= raw;
		sync2_ff <= sync1_ff;
	end
end
logic stp_home, intf, safety, shut_home, entry, deliv, cover_ok, doors;
logic [1:0] surf, paper, a_first, a_second, a_third;
assign stp_home = sync2_ff[0];
assign surf = sync2_ff[2:1];
assign paper = sync2_ff[4:3];
assign a_first = sync2_ff[6:5];
assign a_second = sync2_ff[8:7];
assign a_third = sync2_ff[10:9];
assign safety = sync2_ff[11];
assign shut_home = sync2_ff[12];
assign entry = sync2_ff[13];
assign deliv = sync2_ff[14];
assign cover_ok = sync2_ff[15];
assign intf = sync2_ff[16];
assign doors = sync2_ff[17];

////////////////////////////////////////////////////////////////////////////////
// step divider, free-running; its tick is suppressed while the stacker is halted
logic [11:0] div_ff;
logic [11:0] nxt_div;
logic halt, tick;
assign halt = safety | !cover_ok;
assign tick = (div_ff == STEP_DIV_M1) & !halt;
always_comb begin
	nxt_div = (div_ff == STEP_DIV_M1) ? 12'h000 : div_ff + 12'h001;
end
always_ff @(posedge MCLK) begin
	if (!RST_N) div_ff <= 12'h000;
	else div_ff <= nxt_div;
end

////////////////////////////////////////////////////////////////////////////////
// register file
logic [2:0] ctrl_ff, nxt_ctrl;
logic [15:0] lsteps_ff, nxt_lsteps;
logic [31:0] jtime_ff, nxt_jtime;
logic [IRQ_W-1:0] ist_ff, nxt_ist, mask_ff, nxt_mask, ev;
logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
logic [31:0] rdata_ff, nxt_rdata, wmask, status;
logic wr_go, rd_go;
assign wr_go = S_AXI_AWVALID & S_AXI_WVALID & !bvalid_ff;
assign rd_go = S_AXI_ARVALID & !rvalid_ff;
assign S_AXI_AWREADY = wr_go;
assign S_AXI_WREADY = wr_go;
assign S_AXI_ARREADY = rd_go;
assign S_AXI_BVALID = bvalid_ff;
assign S_AXI_BRESP = bresp_ff;
assign S_AXI_RVALID = rvalid_ff;
assign S_AXI_RRESP = rresp_ff;
assign S_AXI_RDATA = rdata_ff;
assign IRQ = |(ist_ff & mask_ff);
genvar gb;
// byte-lane mask from write strobes
generate
	for (gb = 0; gb < 4; gb++) begin : g_lane
		assign wmask[gb*8 +: 8] = {8{S_AXI_WSTRB[gb]}};
	end
endgenerate
// decode, write merge and read mux; hardware set beats software clear
always_comb begin
	nxt_ctrl = ctrl_ff;
	nxt_lsteps = lsteps_ff;
	nxt_jtime = jtime_ff;
	nxt_mask = mask_ff;
	nxt_ist = ist_ff;
	nxt_bvalid = bvalid_ff & !S_AXI_BREADY;
	nxt_bresp = bresp_ff;
	nxt_rvalid = rvalid_ff & !S_AXI_RREADY;
	nxt_rresp = rresp_ff;
	nxt_rdata = rdata_ff;
	if (wr_go) begin
		nxt_bvalid = 1'b1;
		nxt_bresp = RESP_OKAY;
		if (S_AXI_AWADDR == OFS_CTRL) nxt_ctrl = (ctrl_ff & ~wmask[2:0]) | (S_AXI_WDATA[2:0] & wmask[2:0]);
		else if (S_AXI_AWADDR == OFS_LOWER_STEPS)
			nxt_lsteps = (lsteps_ff & ~wmask[15:0]) | (S_AXI_WDATA[15:0] & wmask[15:0]);
		else if (S_AXI_AWADDR == OFS_JAM_TIME) nxt_jtime = (jtime_ff & ~wmask) | (S_AXI_WDATA & wmask);
		else if (S_AXI_AWADDR == OFS_IRQ_STAT) nxt_ist = ist_ff & ~(S_AXI_WDATA[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
		else if (S_AXI_AWADDR == OFS_IRQ_MASK)
			nxt_mask = (mask_ff & ~wmask[IRQ_W-1:0]) | (S_AXI_WDATA[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
		else if (S_AXI_AWADDR != OFS_STATUS) nxt_bresp = RESP_SLVERR;
	end
	nxt_ist = nxt_ist | ev;
	if (rd_go) begin
		nxt_rvalid = 1'b1;
		nxt_rresp = RESP_OKAY;
		if (S_AXI_ARADDR == OFS_CTRL) nxt_rdata = {29'h0, ctrl_ff};
		else if (S_AXI_ARADDR == OFS_LOWER_STEPS) nxt_rdata = {16'h0, lsteps_ff};
		else if (S_AXI_ARADDR == OFS_JAM_TIME) nxt_rdata = jtime_ff;
		else if (S_AXI_ARADDR == OFS_STATUS) nxt_rdata = status;
		else if (S_AXI_ARADDR == OFS_IRQ_STAT) nxt_rdata = {27'h0, ist_ff};
		else if (S_AXI_ARADDR == OFS_IRQ_MASK) nxt_rdata = {27'h0, mask_ff};
		else begin
			nxt_rdata = 32'h0;
			nxt_rresp = RESP_SLVERR;
		end
	end
end
always_ff @(posedge MCLK) begin
	if (!RST_N) begin
		ctrl_ff <= CTRL_RST;
		lsteps_ff <= LOWER_STEPS_RST;
		jtime_ff <= JAM_TIME_RST;
		mask_ff <= IRQ_MASK_RST;
		ist_ff <= 5'h00;
		bvalid_ff <= 1'b0;
		bresp_ff <= 2'h0;
		rvalid_ff <= 1'b0;
		rresp_ff <= 2'h0;
		rdata_ff <= 32'h0;
	end else begin
		ctrl_ff <= nxt_ctrl;
		lsteps_ff <= nxt_lsteps;
		jtime_ff <= nxt_jtime;
		mask_ff <= nxt_mask;
		ist_ff <= nxt_ist;
		bvalid_ff <= nxt_bvalid;
		bresp_ff <= nxt_bresp;
		rvalid_ff <= nxt_rvalid;
		rresp_ff <= nxt_rresp;
		rdata_ff <= nxt_rdata;
	end
end

////////////////////////////////////////////////////////////////////////////////
// area sensor decode and output bins
fobc_bin_t bst_ff [2];
fobc_bin_t nxt_bst [2];
logic [15:0] bcnt_ff [2];
logic [15:0] nxt_bcnt [2];
logic [1:0] lim_up, lim_dn, over, up, dn, abort;
logic any_up, any_dn;
assign any_up = |lim_up;
assign any_dn = |lim_dn;
genvar gi;
generate
	for (gi = 0; gi < 2; gi++) begin : g_bin
		logic [2:0] area;
		logic homed;
		assign area = {a_first[gi], a_second[gi], a_third[gi]};
		// upper bin uses one table, lower bin the other; lower bottom depends on the unit type
		assign lim_up[gi] = (area == ((gi == 0) ? AREA_UP_UPPER : AREA_UP_LOWER));
		assign lim_dn[gi] = (area == ((gi == 0) ? AREA_LO_UPPER :
			(ctrl_ff[CTRL_BOOKLET] ? AREA_LO_LOWER_BOOK : AREA_LO_LOWER_STACK)));
		// mixed stacking trips one level earlier than large-size stacking
		assign over[gi] = (area == AREA_OVER_1000) | (ctrl_ff[CTRL_MIXED] & (area == AREA_OVER_500));
		// upper bin homes first; lower waits until upper is settled
		assign homed = (gi == 0) | (bst_ff[0] == BN_IDLE) | (bst_ff[0] == BN_PARK);
		always_comb begin
			nxt_bst[gi] = bst_ff[gi];
			nxt_bcnt[gi] = bcnt_ff[gi];
			up[gi] = 1'b0;
			dn[gi] = 1'b0;
			abort[gi] = 1'b0;
			case (bst_ff[gi])
				BN_START: if (homed) nxt_bst[gi] = surf[gi] ? BN_AWAY : BN_SEEK;
				BN_AWAY: begin
					dn[gi] = 1'b1;
					if (!surf[gi]) nxt_bst[gi] = BN_SEEK;
				end
				BN_SEEK: begin
					up[gi] = 1'b1;
					if (surf[gi]) nxt_bst[gi] = BN_IDLE;
				end
				BN_IDLE: begin
					if (STACK_DONE && (STACK_BIN == 1'(gi))) begin
						nxt_bst[gi] = BN_LOWER;
						nxt_bcnt[gi] = lsteps_ff;
					end else if (gi == 0 && ctrl_ff[CTRL_DEST_LOWER]) nxt_bst[gi] = BN_PARK;
				end
				BN_LOWER: begin
					dn[gi] = 1'b1;
					if (bcnt_ff[gi] == 16'h0) nxt_bst[gi] = BN_SEEK;
					else if (tick) nxt_bcnt[gi] = bcnt_ff[gi] - 16'h1;
				end
				BN_PARK: begin
					// raise upper bin until its top limit; lower bin then faces the port
					up[gi] = !any_up;
					if (!ctrl_ff[CTRL_DEST_LOWER]) begin
						nxt_bst[gi] = BN_LOWER;
						nxt_bcnt[gi] = lsteps_ff;
					end
				end
				default: nxt_bst[gi] = BN_START;
			endcase
			// a limit in the travel direction stops the move for both bins
			if ((up[gi] & any_up) | (dn[gi] & any_dn)) begin
				up[gi] = 1'b0;
				dn[gi] = 1'b0;
				if (bst_ff[gi] != BN_PARK) begin
					nxt_bst[gi] = BN_IDLE;
					abort[gi] = 1'b1;
				end
			end
		end
		always_ff @(posedge MCLK) begin
			if (!RST_N) begin
				bst_ff[gi] <= BN_START;
				bcnt_ff[gi] <= 16'h0;
			end else begin
				bst_ff[gi] <= nxt_bst[gi];
				bcnt_ff[gi] <= nxt_bcnt[gi];
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// stapler shift
fobc_stp_t ss_ff, nxt_ss;
logic [15:0] scnt_ff, nxt_scnt, target;
logic pend_ff, nxt_pend, s_move, s_dir;
// ready point from staple position plus a per-size offset
always_comb begin
	case (STAPLE_POS)
		2'h1: target = STAPLE_BASE_REAR;
		2'h2: target = STAPLE_BASE_DUAL;
		default: target = STAPLE_BASE_FRONT;
	endcase
	target = target + ({14'h0, PAPER_SIZE} * STAPLE_SIZE_STEP);
end
// every move starts from home so the step count has a known origin
always_comb begin
	nxt_ss = ss_ff;
	nxt_scnt = scnt_ff;
	nxt_pend = pend_ff;
	s_move = 1'b0;
	s_dir = 1'b0;
	case (ss_ff)
		SS_SEEK: begin
			s_move = !stp_home;
			if (stp_home) begin
				nxt_ss = pend_ff ? SS_OUT : SS_IDLE;
				nxt_pend = 1'b0;
			end
		end
		SS_OUT: begin
			s_move = 1'b1;
			s_dir = 1'b1;
			if (scnt_ff == 16'h0) nxt_ss = SS_READY;
			else if (tick) nxt_scnt = scnt_ff - 16'h1;
		end
		default: ;
	endcase
	if (STAPLE_CMD) begin
		nxt_ss = SS_SEEK;
		nxt_pend = 1'b1;
		nxt_scnt = target;
	end
end
always_ff @(posedge MCLK) begin
	if (!RST_N) begin
		ss_ff <= SS_SEEK;
		scnt_ff <= 16'h0;
		pend_ff <= 1'b0;
	end else begin
		ss_ff <= nxt_ss;
		scnt_ff <= nxt_scnt;
		pend_ff <= nxt_pend;
	end
end

////////////////////////////////////////////////////////////////////////////////
// delivery shutter, sensor high means closed
fobc_sh_t sh_ff, nxt_sh;
logic close_req, sh_move, sh_fwd;
assign close_req = up[0] | dn[0];
always_comb begin
	nxt_sh = sh_ff;
	sh_move = 1'b0;
	sh_fwd = 1'b0;
	case (sh_ff)
		SH_OPEN: begin
			if (close_req) nxt_sh = SH_CLOSING;
			else if (shut_home) nxt_sh = SH_OPENING;
		end
		SH_CLOSING: begin
			sh_move = 1'b1;
			sh_fwd = 1'b1;
			if (shut_home) nxt_sh = SH_SHUT;
		end
		SH_SHUT: if (!close_req) nxt_sh = SH_OPENING;
		default: begin
			sh_move = 1'b1;
			if (!shut_home) nxt_sh = SH_OPEN;
		end
	endcase
end
always_ff @(posedge MCLK) begin
	if (!RST_N) sh_ff <= SH_OPEN;
	else sh_ff <= nxt_sh;
end

////////////////////////////////////////////////////////////////////////////////
// jam detection; check times are in step slots after the sheet start
fobc_jam_t jm_ff, nxt_jm;
logic [15:0] jcnt_ff, nxt_jcnt;
logic door_prev_ff, jam_evt, rep_evt, rep_again;
always_comb begin
	nxt_jm = jm_ff;
	nxt_jcnt = jcnt_ff;
	jam_evt = 1'b0;
	rep_again = 1'b0;
	case (jm_ff)
		JM_IDLE: if (SHEET_START) begin
			nxt_jm = JM_RUN;
			nxt_jcnt = 16'h0;
		end
		JM_RUN: if (tick) begin
			nxt_jcnt = jcnt_ff + 16'h1;
			if (jcnt_ff == jtime_ff[15:0] && !entry) jam_evt = 1'b1;
			else if (jcnt_ff == jtime_ff[31:16]) begin
				if (!deliv) jam_evt = 1'b1;
				else nxt_jm = JM_IDLE;
			end
			if (jam_evt) nxt_jm = JM_JAM;
		end
		default: if (doors && !door_prev_ff) begin
			// paper still in the path after closing means the jam stays
			if (entry | deliv) rep_again = 1'b1;
			else nxt_jm = JM_IDLE;
		end
	endcase
	rep_evt = jam_evt | rep_again;
end
always_ff @(posedge MCLK) begin
	if (!RST_N) begin
		jm_ff <= JM_IDLE;
		jcnt_ff <= 16'h0;
		door_prev_ff <= 1'b0;
	end else begin
		jm_ff <= nxt_jm;
		jcnt_ff <= nxt_jcnt;
		door_prev_ff <= doors;
	end
end

////////////////////////////////////////////////////////////////////////////////
// events, status word and registered actuator outputs
logic [1:0] prev_ff;
assign ev = {(nxt_ss == SS_READY) & (ss_ff == SS_OUT), safety & !prev_ff[1], (|over) & !prev_ff[0], |abort, jam_evt};
assign status = {12'h0, cover_ok, safety, paper, over, any_dn, any_up, jm_ff, ss_ff, sh_ff, bst_ff[1], bst_ff[0]};
always_ff @(posedge MCLK) begin
	if (!RST_N) begin
		prev_ff <= 2'h0;
		STAPLER_READY <= 1'b0;
		JAM_REPORT <= 1'b0;
		JAM_REPEAT <= 1'b0;
		DELIVERY_SUSPEND <= 1'b0;
		STAPLER_SHIFT_MOTOR_STEP <= 1'b0;
		STAPLER_SHIFT_MOTOR_DIR <= 1'b0;
		STAPLE_DRIVE_MOTOR <= 1'b0;
		BIN_SHIFT_MOTOR_STEP <= 2'h0;
		BIN_SHIFT_MOTOR_DIR <= 2'h0;
		STACK_EJECTION_MOTOR_STEP <= 1'b0;
		STACK_EJECTION_MOTOR_DIR <= 1'b0;
		SHUTTER_CLUTCH <= 1'b0;
		LOWER_ROLLER_CLUTCH <= 1'b0;
		MOTOR_POWER_EN <= 1'b0;
		UPPER_MOTOR_POWER_EN <= 1'b0;
	end else begin
		prev_ff <= {safety, |over};
		STAPLER_READY <= (ss_ff == SS_READY);
		JAM_REPORT <= rep_evt;
		JAM_REPEAT <= rep_again;
		DELIVERY_SUSPEND <= (nxt_jm == JM_JAM);
		STAPLER_SHIFT_MOTOR_STEP <= tick & s_move;
		STAPLER_SHIFT_MOTOR_DIR <= s_dir;
		// staple motor locked out in the stopper zone
		STAPLE_DRIVE_MOTOR <= STAPLE_FIRE & (ss_ff == SS_READY) & !intf & !halt;
		BIN_SHIFT_MOTOR_STEP <= {2{tick}} & (up | dn);
		BIN_SHIFT_MOTOR_DIR <= up;
		STACK_EJECTION_MOTOR_STEP <= tick & sh_move;
		STACK_EJECTION_MOTOR_DIR <= sh_fwd;
		SHUTTER_CLUTCH <= sh_move;
		LOWER_ROLLER_CLUTCH <= sh_move;
		MOTOR_POWER_EN <= cover_ok;
		UPPER_MOTOR_POWER_EN <= cover_ok & !safety;
	end
end

////////////////////////////////////////////////////////////////////////////////
// assertions
default clocking cb @(posedge MCLK); endclocking
default disable iff (!RST_N);
a_cover_cut: assert property (!cover_ok |=> !MOTOR_POWER_EN && BIN_SHIFT_MOTOR_STEP == 2'h0)
	else $error("motor supply live with cover open");
a_safety_halt: assert property (safety |=> !UPPER_MOTOR_POWER_EN && !STACK_EJECTION_MOTOR_STEP)
	else $error("upper motor powered with safety switch on");
a_staple_lock: assert property (intf |=> !STAPLE_DRIVE_MOTOR)
	else $error("staple motor driven in interference zone");
a_limit_stop: assert property (any_up |=> (BIN_SHIFT_MOTOR_STEP & BIN_SHIFT_MOTOR_DIR) == 2'h0)
	else $error("bin stepped up past top limit");
a_jam_report: assert property (jam_evt |=> JAM_REPORT && DELIVERY_SUSPEND ##1 !JAM_REPORT)
	else $error("jam not reported as one pulse");
a_jam_again: assert property (jm_ff == JM_JAM && doors && !door_prev_ff && (entry | deliv)
	|=> JAM_REPORT && JAM_REPEAT && jm_ff == JM_JAM)
	else $error("uncleared jam not reported again");
a_shutter_close: assert property (sh_ff == SH_OPEN && close_req |=> sh_ff == SH_CLOSING)
	else $error("shutter not closing for upper bin move");
a_shutter_drive: assert property (STACK_EJECTION_MOTOR_STEP |-> SHUTTER_CLUTCH && LOWER_ROLLER_CLUTCH)
	else $error("shutter stepped without clutches");
a_bin_order: assert property (bst_ff[1] == BN_START && bst_ff[0] inside {BN_START, BN_AWAY, BN_SEEK}
	|=> bst_ff[1] == BN_START)
	else $error("lower bin homed before upper bin");
a_bin_lower: assert property (bst_ff[0] == BN_IDLE && STACK_DONE && !STACK_BIN && !any_dn
	|=> bst_ff[0] == BN_LOWER && bcnt_ff[0] == $past(lsteps_ff))
	else $error("stacked bin not lowered by set count");
a_stapler_home: assert property (ss_ff == SS_SEEK && stp_home && !pend_ff && !STAPLE_CMD
	|=> ss_ff == SS_IDLE && !STAPLER_SHIFT_MOTOR_STEP)
	else $error("stapler moved away from home at idle");
c_jam_seen: cover property (jam_evt ##[1:1000] (jm_ff == JM_IDLE));
c_stapler_ready: cover property (STAPLE_CMD ##[1:1000] STAPLER_READY);
c_park: cover property (bst_ff[0] == BN_PARK && any_up);
endmodule

// file: fobc_pkg.sv
// constants, register map and state types for the finisher output bin control
package fobc_pkg;
	// step-rate divider: one motor step slot every STEP_PERIOD_US
	localparam int CLK_HZ = 20_000_000;
	localparam int STEP_PERIOD_US = 200;
	localparam int STEP_DIV = (CLK_HZ / 1_000_000) * STEP_PERIOD_US;
	localparam logic [11:0] STEP_DIV_M1 = 12'(STEP_DIV - 1);
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LOWER_STEPS = 8'h04;
	localparam logic [7:0] OFS_JAM_TIME = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	// reset values
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [15:0] LOWER_STEPS_RST = 16'h0064;
	localparam logic [31:0] JAM_TIME_RST = 32'h0032_000a;
	localparam logic [4:0] IRQ_MASK_RST = 5'h00;
	// control fields
	localparam int CTRL_DEST_LOWER = 0;
	localparam int CTRL_BOOKLET = 1;
	localparam int CTRL_MIXED = 2;
	// interrupt bits
	localparam int IRQ_JAM = 0;
	localparam int IRQ_LIMIT = 1;
	localparam int IRQ_OVER = 2;
	localparam int IRQ_SAFETY = 3;
	localparam int IRQ_READY = 4;
	localparam int IRQ_W = 5;
	// area sensor patterns, ordered {first, second, third}
	localparam logic [2:0] AREA_UP_UPPER = 3'h0;
	localparam logic [2:0] AREA_LO_UPPER = 3'h5;
	localparam logic [2:0] AREA_UP_LOWER = 3'h2;
	localparam logic [2:0] AREA_LO_LOWER_STACK = 3'h0;
	localparam logic [2:0] AREA_LO_LOWER_BOOK = 3'h1;
	localparam logic [2:0] AREA_OVER_500 = 3'h6;
	localparam logic [2:0] AREA_OVER_1000 = 3'h4;
	// stapler ready offsets in steps from home
	localparam logic [15:0] STAPLE_BASE_FRONT = 16'h0010;
	localparam logic [15:0] STAPLE_BASE_REAR = 16'h0080;
	localparam logic [15:0] STAPLE_BASE_DUAL = 16'h0040;
	localparam logic [15:0] STAPLE_SIZE_STEP = 16'h0008;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {BN_START = 3'b000, BN_AWAY = 3'b001, BN_SEEK = 3'b010,
		BN_IDLE = 3'b011, BN_LOWER = 3'b100, BN_PARK = 3'b101} fobc_bin_t;
	typedef enum logic [1:0] {SS_SEEK = 2'b00, SS_IDLE = 2'b01, SS_OUT = 2'b10,
		SS_READY = 2'b11} fobc_stp_t;
	typedef enum logic [1:0] {SH_OPEN = 2'b00, SH_CLOSING = 2'b01, SH_SHUT = 2'b10,
		SH_OPENING = 2'b11} fobc_sh_t;
	typedef enum logic [1:0] {JM_IDLE = 2'b00, JM_RUN = 2'b01, JM_JAM = 2'b10} fobc_jam_t;
endpackage

// file: fobc_plant.sv
// mechanism model: a stepped axis with a home flag at position zero
`timescale 1ns/100ps
module fobc_plant (
	// clock
	input wire logic clk,
	// motor drive
	input wire logic step,
	input wire logic dir,
	// sensor back to the block
	output logic home
);
	int pos = 2;
	// one step per pulse, the end stop keeps it from going below home
	always @(posedge clk) begin
		if (step) begin
			pos <= dir ? pos + 1 : (pos > 0 ? pos - 1 : 0);
		end
	end
	// home is seen only at the reference point
	assign home = (pos == 0);
endmodule

// file: test_finisher_output_bin_control.sv
// self-checking bench for the finisher output bin control
`timescale 1ns/100ps
module test_finisher_output_bin_control;
	import fobc_pkg::*;
	logic MCLK = 0, RST_N = 0, aw = 0, w = 0, b = 0, ar = 0, r = 0, cmd = 0, fire = 0, sd = 0, sb = 0, ss = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd;
	logic [1:0] rr, bresp, bss, bsd, bsp, af = 2'h2, as = 2'h3, at = 2'h3, pos = 0, psz = 0, hs;
	logic itf = 0, saf = 0, ent = 0, dlv = 0, cov = 0, drs = 1, awr, wr, bv, arr, rv, irq, rdy, jr, jrp, sus;
	logic ssm, ssd, sdm, esm, esd, sc, lc, mpe, upe;
	int mismatches = 0, cmp_count = 0, cyc = 0, out_steps = 0;
	fobc_top uut (.MCLK(MCLK), .RST_N(RST_N), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(aw), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(b), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(ar), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(r), .IRQ(irq), .STAPLE_CMD(cmd),
		.STAPLE_POS(pos), .PAPER_SIZE(psz), .STAPLE_FIRE(fire), .STACK_DONE(sd), .STACK_BIN(sb), .SHEET_START(ss),
		.STAPLER_READY(rdy), .JAM_REPORT(jr), .JAM_REPEAT(jrp), .DELIVERY_SUSPEND(sus),
		.STAPLER_SHIFT_HOME_SENSOR(hs[0]), .STAPLER_INTERFERENCE_SENSOR(itf), .BIN_SURFACE_SENSOR(bss),
		.BIN_PAPER_SENSOR(2'h0), .AREA_SENSOR_FIRST(af), .AREA_SENSOR_SECOND(as), .AREA_SENSOR_THIRD(at),
		.UPPER_BIN_SAFETY_SWITCH(saf), .SHUTTER_HOME_SENSOR(esd), .PATH_ENTRY_SENSOR(ent),
		.PATH_DELIVERY_SENSOR(dlv), .FRONT_COVER_SWITCH(cov), .DOORS_CLOSED(drs),
		.STAPLER_SHIFT_MOTOR_STEP(ssm), .STAPLER_SHIFT_MOTOR_DIR(ssd), .STAPLE_DRIVE_MOTOR(sdm),
		.BIN_SHIFT_MOTOR_STEP(bsp), .BIN_SHIFT_MOTOR_DIR(bsd), .STACK_EJECTION_MOTOR_STEP(esm),
		.STACK_EJECTION_MOTOR_DIR(esd), .SHUTTER_CLUTCH(sc), .LOWER_ROLLER_CLUTCH(lc), .MOTOR_POWER_EN(mpe),
		.UPPER_MOTOR_POWER_EN(upe));
	// stapler carriage and both bins as stepped axes
	fobc_plant p_st (.clk(MCLK), .step(ssm), .dir(ssd), .home(hs[0]));
	// a bin homes at the top, so an up step moves it toward the surface flag
	fobc_plant p_b0 (.clk(MCLK), .step(bsp[0]), .dir(!bsd[0]), .home(bss[0]));
	fobc_plant p_b1 (.clk(MCLK), .step(bsp[1]), .dir(!bsd[1]), .home(bss[1]));
	assign hs[1] = 1'b0;
	always #25 MCLK = ~MCLK;
	////////////////////////////////////////////////////////////////////////////////
	// carriage steps taken away from home, cleared by the stapler test
	always @(posedge MCLK) begin
		if (ssm && ssd) out_steps++;
	end
	// hang guard: the stapler walk of sixteen step slots is the long part
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// write: address and data together, held until taken, then wait for the response
	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		awa <= a; wd <= d; aw <= 1; w <= 1; b <= 1;
		do @(posedge MCLK); while (awr !== 1'b1);
		aw <= 0; w <= 0;
		do @(posedge MCLK); while (bv !== 1'b1);
		b <= 0;
		// let an edge pass so a following call never re-raises bready in this step
		@(posedge MCLK);
	endtask
	task automatic rd32(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
		ara <= a; ar <= 1; r <= 1;
		do @(posedge MCLK); while (arr !== 1'b1);
		ar <= 0;
		do @(posedge MCLK); while (rv !== 1'b1);
		d = rd; e = rr;
		r <= 0;
		// let an edge pass so a following call never re-raises rready in this step
		@(posedge MCLK);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge MCLK);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	logic [31:0] v;
	logic [1:0] e;
	initial begin
		wt(5);
		RST_N <= 1;
		// reset values, unmapped access refused
		rd32(OFS_LOWER_STEPS, v, e); chk("lower_steps", 32'h0000_0064, v);
		rd32(OFS_JAM_TIME, v, e); chk("jam_time", JAM_TIME_RST, v);
		rd32(8'h18, v, e); chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, e});
		// open cover keeps the motor supply off
		chk("power_cover_open", 0, mpe);
		cov <= 1; wt(8); chk("power_cover_closed", 1, mpe);
		// interference sensor inhibits the staple motor
		itf <= 1; fire <= 1; wt(8); chk("staple_inhibit", 0, sdm);
		fire <= 0; itf <= 0;
		$display("test power and stapler done");
		// area patterns: upper top 000, upper bottom 101, lower over 1000 = 100
		af <= 2'h2; as <= 2'h2; at <= 2'h2; wt(6);
		rd32(OFS_STATUS, v, e); chk("upper_top", 1, v[12]);
		af <= 2'h3; at <= 2'h3; wt(6);
		rd32(OFS_STATUS, v, e); chk("upper_bottom", 1, v[13]);
		af <= 2'h3; as <= 2'h1; at <= 2'h1; wt(6);
		rd32(OFS_STATUS, v, e); chk("lower_over", 1, v[15]);
		af <= 2'h2; as <= 2'h3; at <= 2'h3;
		$display("test area done");
		// both bins were stopped by the top limit above and now sit idle
		wt(4); sb <= 0; sd <= 1; wt(1); sd <= 0;
		rd32(OFS_STATUS, v, e); chk("bin_lower", BN_LOWER, v[2:0]);
		$display("test bin lower done");
		// safety switch: upper motor supply off, event latched, unmasked, cleared
		wr32(OFS_IRQ_MASK, 32'h8);
		saf <= 1; wt(8); chk("upper_power", 0, upe);
		chk("irq_on", 1, irq);
		saf <= 0; wr32(OFS_IRQ_STAT, 32'h8); wt(2); chk("irq_clear", 0, irq);
		$display("test safety done");
		// jam: entry sensor empty at its check slot
		wr32(OFS_JAM_TIME, 32'h0002_0001);
		ss <= 1; wt(1); ss <= 0;
		do @(posedge MCLK); while (jr !== 1'b1);
		wt(2); chk("suspend", 1, sus);
		ent <= 1; drs <= 0; wt(6); drs <= 1;
		do @(posedge MCLK); while (jr !== 1'b1);
		chk("jam_repeat", 1, jrp);
		ent <= 0; drs <= 0; wt(6); drs <= 1; wt(10);
		chk("jam_cleared", 0, sus);
		$display("test jam done");
		// front point, smallest size: carriage leaves home by the base offset only
		out_steps = 0; cmd <= 1; wt(1); cmd <= 0;
		do @(posedge MCLK); while (rdy !== 1'b1);
		chk("staple_steps", STAPLE_BASE_FRONT, out_steps);
		// sensor first, so the fire request never meets a stale clear zone
		itf <= 1; wt(4); fire <= 1; wt(8); chk("staple_inhibit_ready", 0, sdm);
		itf <= 0; wt(8); chk("staple_fire", 1, sdm);
		fire <= 0;
		$display("test stapler shift done");
		end_of_test();
	end
endmodule
